// [include/cpuck_pkg.sv]
// Constants, field positions and carriers of the clock source switcher.
// Assumes one hclk domain and 8-bit registers on 32-bit bus words.
package cpuck_pkg;
    // Register byte offsets
    localparam logic [7:0] CPUCK_RUN_OFS = 8'h00;
    localparam logic [7:0] CPUCK_SEL_OFS = 8'h04;
    localparam logic [7:0] CPUCK_SUB_OFS = 8'h08;
    localparam logic [7:0] CPUCK_MODE_OFS = 8'h0C;
    localparam logic [7:0] CPUCK_STS_OFS = 8'h10;
    localparam logic [7:0] CPUCK_STC_OFS = 8'h14;
    localparam int CPUCK_AW = 8;
    // Run control fields
    localparam int RUN_XSTOP = 7;
    localparam int RUN_ONE = 6;
    localparam int RUN_MIDEN = 1;
    localparam int RUN_FSTOP = 0;
    // Source select fields
    localparam int SEL_CPU_ST = 7;
    localparam int SEL_CPU_CH = 6;
    localparam int SEL_MAIN_ST = 5;
    localparam int SEL_MAIN_CH = 4;
    localparam int SEL_ONC_ST = 1;
    localparam int SEL_ONC_CH = 0;
    // Subsystem, mode and stabilization fields
    localparam int SUB_SLOW = 0;
    localparam int MODE_EXT = 7;
    localparam int MODE_PINS = 6;
    localparam int MODE_GAIN = 0;
    localparam int STS_W = 3;
    // Reset values
    localparam logic [7:0] CPUCK_RUN_RST = 8'hC0;
    localparam logic [7:0] CPUCK_SEL_RST = 8'h00;
    localparam logic [7:0] CPUCK_SUB_RST = 8'h00;
    localparam logic [7:0] CPUCK_MODE_RST = 8'h00;
    localparam logic [2:0] CPUCK_STS_RST = 3'h7;
    // Stabilization status: crystal cycles 2**n per bit, bit 7 first
    localparam logic [7:0][4:0] CPUCK_STAB_EXP = {5'd8, 5'd9, 5'd10, 5'd11, 5'd13, 5'd15, 5'd17, 5'd18};
    localparam int CPUCK_UNIT_W = 19;
    // Software waits, kept for reference by drivers
    localparam real CPUCK_MID_WAIT_US = 4.0;
    localparam real CPUCK_SLOW_WAIT_US = 210.0;
    localparam real CPUCK_HCLK_MHZ = 40.0;
    localparam int CPUCK_GAIN_LIMIT_MHZ = 10;
    // Default hclk cycles per crystal cycle (40 MHz over 10 MHz)
    localparam int CPUCK_X1_PRESCALE = 4;
    // Dead cycles with the CPU clock gated during a swap
    localparam logic [1:0] CPUCK_GAP = 2'h2;
    // Oscillator ready inputs
    localparam int RDY_FAST = 0;
    localparam int RDY_MID = 1;
    localparam int RDY_SLOW = 2;
    localparam int RDY_X1 = 3;
    localparam int RDY_N = 4;

    // Switch machine states, one-hot
    typedef enum logic [2:0] {
        SW_IDLE = 3'b001,
        SW_GATE = 3'b010,
        SW_SWAP = 3'b100
    } cpuck_sw_e;

    // Oscillator enables driven to the analog blocks
    typedef struct packed {
        logic x1_run;
        logic ext_clk;
        logic gain_high;
        logic slow_run;
        logic mid_run;
        logic fast_run;
    } cpuck_osc_s;

    // Active CPU clock source
    typedef struct packed {
        logic subsys;
        logic main_x1;
        logic onchip_mid;
    } cpuck_src_s;
endpackage

// [logic/cpuck_switcher.sv]
// CPU clock source switcher: registers, oscillator enables,
// crystal stabilization counter and glitch-free source selection.
// Assumes an AHB-Lite master with single word transfers and
// asynchronous oscillator ready pins from the analog blocks.
//
// Contract
// - Run control: crystal stop, mid enable, fast stop
// - Select bit 0 picks mid on-chip oscillator
// - Bit 1 shows mid in use
// - Subsystem bit 0 starts slow oscillator
// - Select bit 6 makes subsystem CPU clock
// - Bit 7 shows subsystem drives CPU
// - Mode bits enable crystal or external input
// - Three-bit field chooses crystal wait
// - Clearing crystal stop starts crystal when the pins are enabled
// - Counter status fills ones from bit 7
// - Select bit 4 picks high-speed system clock
// - Bit 5 shows high-speed system clock used
`timescale 1ns/1ps
module cpuck_switcher
    import cpuck_pkg::*;
#(
    parameter int X1_PRESCALE = CPUCK_X1_PRESCALE,
    parameter logic [7:0][4:0] STAB_EXP = CPUCK_STAB_EXP
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Oscillator ready pins
    input wire logic [RDY_N-1:0] osc_ready,
    // Oscillator enables and CPU clock control
    output cpuck_osc_s osc_en,
    output cpuck_src_s cpu_src,
    output logic cpu_clk_gate
);

    // Software registers
    logic crystal_osc_stop;
    logic mid_osc_enable;
    logic fast_onchip_osc_stop;
    logic onchip_osc_choice;
    logic main_clock_source_choice;
    logic cpu_clock_source_choice;
    logic slow_osc_select;
    logic external_clock_input_sel;
    logic crystal_pins_enable;
    logic crystal_gain_high;
    logic [STS_W-1:0] stabilization_time_select;

    // Bus address phase capture
    logic wr_pend;
    logic [CPUCK_AW-1:0] wr_addr;
    wire logic addr_phase;
    wire logic [CPUCK_AW-1:0] a_ofs;
    wire logic [7:0] wb;

    assign addr_phase = hsel & htrans[1] & hready;
    assign a_ofs = haddr[CPUCK_AW-1:0];
    assign wb = hwdata[7:0];

    // Ready pins, two flops before use
    logic [RDY_N-1:0] rdy_m;
    logic [RDY_N-1:0] rdy_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdy_m <= '0;
            rdy_s <= '0;
        end else begin
            rdy_m <= osc_ready;
            rdy_s <= rdy_m;
        end
    end

    // Write decode in the data phase
    wire logic we_run;
    wire logic we_sel;
    wire logic we_sub;
    wire logic we_mode;
    wire logic we_sts;

    assign we_run = wr_pend && (wr_addr == CPUCK_RUN_OFS);
    assign we_sel = wr_pend && (wr_addr == CPUCK_SEL_OFS);
    assign we_sub = wr_pend && (wr_addr == CPUCK_SUB_OFS);
    assign we_mode = wr_pend && (wr_addr == CPUCK_MODE_OFS);
    assign we_sts = wr_pend && (wr_addr == CPUCK_STS_OFS);

    // Bus capture; zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= addr_phase & hwrite;
            wr_addr <= a_ofs;
        end
    end

    // Run control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crystal_osc_stop <= CPUCK_RUN_RST[RUN_XSTOP];
            mid_osc_enable <= CPUCK_RUN_RST[RUN_MIDEN];
            fast_onchip_osc_stop <= CPUCK_RUN_RST[RUN_FSTOP];
        end else if (we_run) begin
            crystal_osc_stop <= wb[RUN_XSTOP];
            mid_osc_enable <= wb[RUN_MIDEN];
            fast_onchip_osc_stop <= wb[RUN_FSTOP];
        end
    end

    // Source select choices
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_clock_source_choice <= CPUCK_SEL_RST[SEL_CPU_CH];
            main_clock_source_choice <= CPUCK_SEL_RST[SEL_MAIN_CH];
            onchip_osc_choice <= CPUCK_SEL_RST[SEL_ONC_CH];
        end else if (we_sel) begin
            cpu_clock_source_choice <= wb[SEL_CPU_CH];
            main_clock_source_choice <= wb[SEL_MAIN_CH];
            onchip_osc_choice <= wb[SEL_ONC_CH];
        end
    end

    // Subsystem, mode and stabilization select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_osc_select <= CPUCK_SUB_RST[SUB_SLOW];
            external_clock_input_sel <= CPUCK_MODE_RST[MODE_EXT];
            crystal_pins_enable <= CPUCK_MODE_RST[MODE_PINS];
            crystal_gain_high <= CPUCK_MODE_RST[MODE_GAIN];
            stabilization_time_select <= CPUCK_STS_RST;
        end else begin
            if (we_sub) begin
                slow_osc_select <= wb[SUB_SLOW];
            end
            if (we_mode) begin
                external_clock_input_sel <= wb[MODE_EXT];
                crystal_pins_enable <= wb[MODE_PINS];
                crystal_gain_high <= wb[MODE_GAIN];
            end
            if (we_sts) begin
                stabilization_time_select <= wb[STS_W-1:0];
            end
        end
    end

    // Crystal request; external mode only with the pins enabled
    wire logic x1_req;
    wire logic ext_mode;

    assign x1_req = crystal_pins_enable & ~crystal_osc_stop;
    assign ext_mode = crystal_pins_enable & external_clock_input_sel;

    // Stabilization counter in crystal cycles
    localparam int PW = (X1_PRESCALE > 1) ? $clog2(X1_PRESCALE) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(X1_PRESCALE - 1);
    logic [PW-1:0] pre_cnt;
    logic [CPUCK_UNIT_W-1:0] unit_cnt;
    logic x1_was_req;
    wire logic x1_start;
    wire logic unit_tick;
    wire logic unit_full;

    assign x1_start = x1_req & ~x1_was_req;
    assign unit_tick = (pre_cnt == PRE_LAST);
    assign unit_full = unit_cnt[CPUCK_UNIT_W-1];

    // Restart on every crystal start; hold at the top
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            x1_was_req <= 1'b0;
            pre_cnt <= '0;
            unit_cnt <= '0;
        end else begin
            x1_was_req <= x1_req;
            if (!x1_req || x1_start) begin
                pre_cnt <= '0;
                unit_cnt <= '0;
            end else if (!unit_full) begin
                pre_cnt <= unit_tick ? '0 : pre_cnt + 1'b1;
                if (unit_tick) begin
                    unit_cnt <= unit_cnt + 1'b1;
                end
            end
        end
    end

    // Status bits fill from bit 7 downward
    logic [7:0] stab_status;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_stab
            localparam logic [CPUCK_UNIT_W-1:0] LIM = CPUCK_UNIT_W'(1) << STAB_EXP[gi];
            // Bit 7 has the shortest limit, so ones grow downward
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    stab_status[gi] <= 1'b0;
                end else begin
                    stab_status[gi] <= x1_req & ~x1_start & (unit_cnt >= LIM);
                end
            end
        end
    endgenerate

    // Chosen wait reached: value n needs n+1 leading ones
    wire logic [2:0] sts_bit;
    wire logic x1_stable;

    assign sts_bit = 3'h7 - stabilization_time_select;
    // External input has no wait at all
    assign x1_stable = x1_req & (ext_mode | stab_status[sts_bit]);

    // Active source and the requested one
    cpuck_src_s act;
    cpuck_src_s tgt;
    cpuck_sw_e sw_state;
    logic [1:0] gap_cnt;
    wire logic tgt_ready;
    wire logic need_swap;

    assign tgt = '{subsys: cpu_clock_source_choice, main_x1: main_clock_source_choice,
                   onchip_mid: onchip_osc_choice};

    // Only swap to a source that is really running
    assign tgt_ready = tgt.subsys ? rdy_s[RDY_SLOW] :
                       tgt.main_x1 ? (x1_stable & rdy_s[RDY_X1]) :
                       tgt.onchip_mid ? rdy_s[RDY_MID] : rdy_s[RDY_FAST];
    assign need_swap = (tgt != act) & tgt_ready;

    // Swap machine: gate, swap during the gap, ungate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_state <= SW_IDLE;
            gap_cnt <= '0;
            act <= '0;
        end else begin
            case (sw_state)
                SW_IDLE: begin
                    gap_cnt <= '0;
                    if (need_swap) begin
                        sw_state <= SW_GATE;
                    end
                end
                SW_GATE: begin
                    gap_cnt <= gap_cnt + 1'b1;
                    if (gap_cnt == CPUCK_GAP - 2'h1) begin
                        sw_state <= SW_SWAP;
                    end
                end
                SW_SWAP: begin
                    // Choice may have moved; take what is ready now
                    if (tgt_ready) begin
                        act <= tgt;
                    end
                    sw_state <= SW_IDLE;
                end
                default: begin
                    sw_state <= SW_IDLE;
                end
            endcase
        end
    end

    // Clock controls; the gate reopens one edge after the new source is out, never together
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_src <= '0;
            cpu_clk_gate <= 1'b1;
        end else begin
            cpu_src <= act;
            cpu_clk_gate <= (sw_state == SW_IDLE) & ~need_swap & (cpu_src == act);
        end
    end

    // Oscillator enables; a source in use keeps running
    wire logic fast_in_use;
    wire logic mid_in_use;

    assign fast_in_use = ~act.subsys & ~act.main_x1 & ~act.onchip_mid;
    assign mid_in_use = ~act.subsys & ~act.main_x1 & act.onchip_mid;

    // Guards against a stop before the status confirmed the move
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_en <= '0;
        end else begin
            osc_en.fast_run <= ~fast_onchip_osc_stop | fast_in_use;
            osc_en.mid_run <= mid_osc_enable | mid_in_use;
            osc_en.slow_run <= slow_osc_select | act.subsys;
            osc_en.x1_run <= x1_req | act.main_x1;
            osc_en.ext_clk <= ext_mode;
            osc_en.gain_high <= crystal_gain_high;
        end
    end

    // Read views with fixed and reserved bits
    wire logic [7:0] rv_run;
    wire logic [7:0] rv_sel;
    wire logic [7:0] rv_mode;
    wire logic [7:0] rd_byte;

    assign rv_run = {crystal_osc_stop, 1'b1, 4'h0, mid_osc_enable, fast_onchip_osc_stop};
    // Status bits follow the active source, not the choice
    assign rv_sel = {act.subsys, cpu_clock_source_choice, act.main_x1, main_clock_source_choice,
                     2'h0, act.onchip_mid, onchip_osc_choice};
    assign rv_mode = {external_clock_input_sel, crystal_pins_enable, 5'h00, crystal_gain_high};

    // Address decode; unmapped reads return zero
    assign rd_byte = (a_ofs == CPUCK_RUN_OFS) ? rv_run :
                     (a_ofs == CPUCK_SEL_OFS) ? rv_sel :
                     (a_ofs == CPUCK_SUB_OFS) ? {7'h00, slow_osc_select} :
                     (a_ofs == CPUCK_MODE_OFS) ? rv_mode :
                     (a_ofs == CPUCK_STS_OFS) ? {5'h00, stabilization_time_select} :
                     (a_ofs == CPUCK_STC_OFS) ? stab_status : 8'h00;

    // Read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_phase && !hwrite) begin
                hrdata <= {24'h000000, rd_byte};
            end
        end
    end

endmodule

// [tb/cpuck_switcher_asserts.sv]
// Port-level checker for the clock source switcher.
// Assumes one hclk domain; bound from the bench top file.
`timescale 1ns/1ps
module cpuck_switcher_asserts
    import cpuck_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus slave side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Oscillator link
    input wire logic [RDY_N-1:0] osc_ready,
    input wire cpuck_osc_s osc_en,
    input wire cpuck_src_s cpu_src,
    input wire logic cpu_clk_gate
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Bus answers never stall or fail
    resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
    ready_high_a: assert property (hreadyout == 1'b1) else $error("hreadyout low");
    rdata_upper_a: assert property (hrdata[31:8] == 24'h0) else $error("hrdata upper bits set");
    // Source only changes while the CPU clock is held off
    swap_gated_a: assert property (!$stable(cpu_src) |-> !cpu_clk_gate && !$past(cpu_clk_gate))
        else $error("source changed with clock open");
    gate_window_a: assert property ($fell(cpu_clk_gate) |-> (!cpu_clk_gate)[*2] ##[1:4] cpu_clk_gate)
        else $error("gate window wrong");
    // Fast and mid sources keep running in use, slow and crystal run when picked; the enables are still zero on the release edge
    fast_kept_a: assert property (cpu_src == 3'b000 && $past(hresetn) |-> ##1 osc_en.fast_run)
        else $error("fast oscillator stopped in use");
    mid_kept_a: assert property (cpu_src == 3'b001 |-> osc_en.mid_run)
        else $error("mid oscillator stopped in use");
    slow_on_a: assert property ($rose(cpu_src.subsys) |-> osc_en.slow_run)
        else $error("subsystem picked while slow off");
    x1_on_a: assert property ($rose(cpu_src.main_x1) |-> osc_en.x1_run)
        else $error("crystal picked while off");

    // Main switches seen
    cover property ($rose(cpu_src.onchip_mid));
    cover property ($rose(cpu_src.subsys));
    cover property ($rose(cpu_src.main_x1));
endmodule

// [tb/cpuck_switcher_bench.sv]
// Self-checking bench for the clock source switcher.
// Assumes the package and checker are compiled first; shortened counts.
`timescale 1ns/1ps
module cpu_clock_source_switcher_bench;
    import cpuck_pkg::*;
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [RDY_N-1:0] osc_ready;
    logic hreadyout, hresp, cpu_clk_gate;
    logic [31:0] hrdata;
    cpuck_osc_s osc_en;
    cpuck_src_s cpu_src;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] rst_v [7] = '{8'hC0, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00};
    logic [7:0] wm [7] = '{8'h83, 8'h51, 8'h01, 8'hC1, 8'h07, 8'h00, 8'h00};

    // Short stabilization so the crystal path fits the run
    cpuck_switcher #(.X1_PRESCALE(1), .STAB_EXP({5'd4, 5'd5, 5'd6, 5'd7, 5'd8, 5'd9, 5'd10, 5'd11})) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .osc_ready(osc_ready), .osc_en(osc_en), .cpu_src(cpu_src), .cpu_clk_gate(cpu_clk_gate));

    // Clock and hang guard
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end

    // Select read model: status bits mirror settled choices
    function automatic logic [7:0] sel_rd(input logic [7:0] c);
        return (c & 8'h51) | ((c & 8'h51) << 1);
    endfunction

    task automatic finish_test();
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One single transfer; entered right after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Write, then let the registered enables settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        repeat (2) @(posedge hclk);
    endtask

    task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        int n;
        n = 0;
        do begin
            bus(1'b0, a, 8'h00);
            n++;
        end while ((rd[7:0] & m) !== v && n < 200);
        chk("poll", {24'h0, v}, {24'h0, rd[7:0] & m});
    endtask

    // Start target, wait, select, confirm, stop fast, restart fast, then return to fast; the target stays on
    task automatic sw(input logic [7:0] sa, sd, input int r, e, input logic [7:0] sl, sm, rn,
                      input logic [2:0] se, input real w);
        wr(sa, sd);
        chk("target enable", 1, osc_en[e]);
        osc_ready[r] <= 1'b1;
        // Software settling time in hclk cycles; the crystal uses its counter instead
        repeat (int'(w * CPUCK_HCLK_MHZ)) @(posedge hclk);
        if (sm == 8'h20) begin
            poll(CPUCK_STC_OFS, 8'hE0, 8'hE0);
            chk("fill", 0, {24'h0, ~rd[7:0] & 8'(~rd[7:0] + 8'h1)});
        end
        wr(CPUCK_SEL_OFS, sl);
        poll(CPUCK_SEL_OFS, sm, sm);
        chk("source", {29'h0, se}, {29'h0, cpu_src});
        bus(1'b0, CPUCK_SEL_OFS, 8'h00);
        chk("select read", {24'h0, sel_rd(sl)}, rd);
        wr(CPUCK_RUN_OFS, rn | 8'h01);
        chk("fast stopped", 0, osc_en.fast_run);
        osc_ready[RDY_FAST] <= 1'b0;
        wr(CPUCK_RUN_OFS, rn);
        osc_ready[RDY_FAST] <= 1'b1;
        wr(CPUCK_SEL_OFS, 8'h00);
        poll(CPUCK_SEL_OFS, sm, 8'h00);
        chk("back on fast", 0, {29'h0, cpu_src});
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        osc_ready = 4'h1;
        rd = $urandom(72);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, then random reserved and read-only bits, unmapped last
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 8'(4 * i), 8'h00);
            chk("reset value", {24'h0, rst_v[i]}, rd);
            bus(1'b1, 8'(4 * i), (8'($urandom) & ~wm[i]) | rst_v[i]);
            bus(1'b0, 8'(4 * i), 8'h00);
            chk("reserved bits", {24'h0, rst_v[i]}, rd);
        end
        // Stop request on the source in use is overridden
        wr(CPUCK_RUN_OFS, 8'hC1);
        chk("fast kept", 1, osc_en.fast_run);
        wr(CPUCK_RUN_OFS, 8'hC0);
        sw(CPUCK_RUN_OFS, 8'hC2, RDY_MID, 1, 8'h01, 8'h02, 8'hC2, 3'b001, CPUCK_MID_WAIT_US);
        wr(CPUCK_RUN_OFS, 8'hC0);
        chk("mid stopped", 0, osc_en.mid_run);
        sw(CPUCK_SUB_OFS, 8'h01, RDY_SLOW, 2, 8'h40, 8'h80, 8'hC0, 3'b100, CPUCK_SLOW_WAIT_US);
        wr(CPUCK_SUB_OFS, 8'h00);
        chk("slow stopped", 0, osc_en.slow_run);
        wr(CPUCK_STS_OFS, 8'h02);
        wr(CPUCK_RUN_OFS, 8'h40);
        sw(CPUCK_MODE_OFS, 8'h40, RDY_X1, 5, 8'h10, 8'h20, 8'h40, 3'b010, 0.0);
        wr(CPUCK_RUN_OFS, 8'hC0);
        chk("crystal stopped", 0, osc_en.x1_run);
        // Restart clears the counter: bit 7 stays low for its first units
        wr(CPUCK_RUN_OFS, 8'h40);
        bus(1'b0, CPUCK_STC_OFS, 8'h00);
        chk("count restart", 0, {24'h0, rd[7:0] & 8'h80});
        wr(CPUCK_MODE_OFS, 8'hC1);
        chk("mode enables", 3'b111, {osc_en.x1_run, osc_en.ext_clk, osc_en.gain_high});
        // External input: longest wait chosen, yet the switch must not wait for the count
        wr(CPUCK_STS_OFS, 8'h07);
        wr(CPUCK_SEL_OFS, 8'h10);
        poll(CPUCK_SEL_OFS, 8'h20, 8'h20);
        chk("external source", {29'h0, 3'b010}, {29'h0, cpu_src});
        finish_test();
    end
endmodule

bind cpuck_switcher cpuck_switcher_asserts u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .osc_ready(osc_ready), .osc_en(osc_en), .cpu_src(cpu_src), .cpu_clk_gate(cpu_clk_gate)
);
